//--- logic/usr_pkg.sv
// usr_pkg: shared constants of the usb link-state block (reset, suspend, resume).
// assumes a 100 MHz system clock; all intervals are derived from CLK_PERIOD_NS.
package usr_pkg;

  // ------------------------------------------------------------
  // clock and interval figures
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_RST_DET_NS = 68_000;      // se0 length that means host reset
  localparam int T_CHIRP_K_NS = 1_500_000;   // device chirp-k length
  localparam int T_CHIRP_WAIT_NS = 2_000_000; // wait for host chirp-kj
  localparam int T_SUSP_DET_NS = 3_000_000;  // idle length before suspend decision
  localparam int T_FS_CHECK_NS = 100_000;    // line check after full-speed fallback

  // least times round up to whole cycles
  localparam int RST_DET_CYC = (T_RST_DET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CHIRP_K_CYC = (T_CHIRP_K_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CHIRP_WAIT_CYC = (T_CHIRP_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SUSP_DET_CYC = (T_SUSP_DET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FS_CHECK_CYC = (T_FS_CHECK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ------------------------------------------------------------
  // utmi line state codes and register layout
  // ------------------------------------------------------------
  localparam logic [1:0] LS_SE0 = 2'h0;
  localparam logic [1:0] LS_J = 2'h1;
  localparam logic [1:0] LS_K = 2'h2;

  localparam int CNT_W = 20;
  localparam int DATA_W = 8;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] DMA_STATE_RST = 8'h00;
  localparam logic REG_SEL_CFG = 1'h0;
  localparam logic REG_SEL_DMA = 1'h1;
  localparam int DMA_MODE_BIT = 0; // bit of dma_port_state_reg that selects direct access

  typedef enum logic [2:0] {
    USR_FS_OP, USR_HS_OP, USR_CHIRP_K, USR_CHIRP_WAIT, USR_FS_CHECK, USR_SUSPEND, USR_RESUME
  } usr_state_t;

endpackage

//--- logic/usr_dur_cnt.sv
// usr_dur_cnt: saturating duration counter used to time line conditions.
// assumes clear and run are synchronous to clk.
`timescale 1ns/1ns
`default_nettype none
module usr_dur_cnt #(
  parameter int CW = 20
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire logic clear,
  input wire logic run,
  // count
  output logic [CW-1:0] cnt
);

  // saturate instead of wrapping so a very long condition never looks short
  always_ff @(posedge clk) begin
    if (!rstn || clear) begin
      cnt <= '0;
    end else if (run && (cnt != {CW{1'b1}})) begin
      cnt <= cnt + {{(CW-1){1'b0}}, 1'b1};
    end
  end

endmodule
`default_nettype wire

//--- logic/usr_link_state.sv
// usr_link_state: usb 2.0 device link-state logic (reset, suspend, resume).
// assumes utmi line_state and rx_active synchronous to clk; the phy clock may stop in suspend.
`timescale 1ns/1ns
`default_nettype none
module usr_link_state #(
  parameter int RST_DET_CYC = usr_pkg::RST_DET_CYC,
  parameter int CHIRP_K_CYC = usr_pkg::CHIRP_K_CYC,
  parameter int CHIRP_WAIT_CYC = usr_pkg::CHIRP_WAIT_CYC,
  parameter int SUSP_DET_CYC = usr_pkg::SUSP_DET_CYC,
  parameter int FS_CHECK_CYC = usr_pkg::FS_CHECK_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // utmi receive side
  input wire logic [1:0] line_state,
  input wire logic rx_active,
  // register write port
  input wire logic reg_we,
  input wire logic reg_sel,
  input wire logic [usr_pkg::DATA_W-1:0] reg_wdata,
  // utmi control
  output logic transceiver_speed_sel,
  output logic termination_sel,
  output logic chirp_k_out,
  // link status
  output logic host_reset_active,
  output logic suspend_n_out,
  output logic hs_mode,
  // register contents
  output logic [usr_pkg::DATA_W-1:0] cfg_reg,
  output logic [usr_pkg::DATA_W-1:0] dma_port_state_reg,
  output logic bus_direct_mode
);
  import usr_pkg::*;

  // ------------------------------------------------------------
  // state and counters
  // ------------------------------------------------------------
  usr_state_t state_reg, state_next;
  logic [CNT_W-1:0] se0_cnt, idle_cnt, phase_cnt;
  logic kseen_reg;
  logic prev_hs_reg, prev_hs_next;
  logic se0_run, idle_run, reset_end;

  function automatic logic hit(input logic [CNT_W-1:0] c, input int lim);
    hit = (c >= CNT_W'(lim));
  endfunction

  // se0 without packet traffic, counted only in full-speed operation
  assign se0_run = (state_reg == USR_FS_OP) && !rx_active && (line_state == LS_SE0);
  // idle is se0 in high speed and j in full speed; a packet restarts it
  assign idle_run = !rx_active && (((state_reg == USR_HS_OP) && (line_state == LS_SE0)) ||
                    ((state_reg == USR_FS_OP) && (line_state == LS_J)));
  assign reset_end = (state_reg == USR_CHIRP_WAIT) && (state_next != USR_CHIRP_WAIT);
  // speed memory is taken on suspend entry; only a high-speed fallback passes through fs_check
  assign prev_hs_next = ((state_next == USR_SUSPEND) && (state_reg != USR_SUSPEND)) ?
                        (state_reg == USR_FS_CHECK) : prev_hs_reg;

  usr_dur_cnt #(.CW(CNT_W)) u_se0_cnt (
    .clk(clk), .rstn(rstn), .clear(!se0_run), .run(1'b1), .cnt(se0_cnt)
  );
  usr_dur_cnt #(.CW(CNT_W)) u_idle_cnt (
    .clk(clk), .rstn(rstn), .clear(!idle_run), .run(1'b1), .cnt(idle_cnt)
  );
  usr_dur_cnt #(.CW(CNT_W)) u_phase_cnt (
    .clk(clk), .rstn(rstn), .clear(state_next != state_reg), .run(1'b1), .cnt(phase_cnt)
  );

  // ------------------------------------------------------------
  // link state machine
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      USR_FS_OP: begin
        // reset outranks suspend: se0 is never full-speed idle
        if (hit(se0_cnt, RST_DET_CYC)) begin
          state_next = USR_CHIRP_K;
        end else if (hit(idle_cnt, SUSP_DET_CYC)) begin
          state_next = USR_SUSPEND;
        end
      end
      USR_HS_OP: begin
        if (hit(idle_cnt, SUSP_DET_CYC)) begin
          state_next = USR_FS_CHECK;
        end
      end
      USR_CHIRP_K: begin
        if (hit(phase_cnt, CHIRP_K_CYC)) begin
          state_next = USR_CHIRP_WAIT;
        end
      end
      USR_CHIRP_WAIT: begin
        if (kseen_reg && (line_state == LS_J)) begin
          state_next = USR_HS_OP;
        end else if (hit(phase_cnt, CHIRP_WAIT_CYC)) begin
          state_next = USR_FS_OP;
        end
      end
      USR_FS_CHECK: begin
        if (hit(phase_cnt, FS_CHECK_CYC)) begin
          // j means suspend; anything else is handed to full-speed reset detection
          state_next = (line_state == LS_J) ? USR_SUSPEND : USR_FS_OP;
        end
      end
      USR_SUSPEND: begin
        if (line_state == LS_K) begin
          state_next = USR_RESUME;
        end
      end
      USR_RESUME: begin
        if (line_state == LS_SE0) begin
          state_next = prev_hs_reg ? USR_HS_OP : USR_FS_OP;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= USR_FS_OP;
    end else begin
      state_reg <= state_next;
    end
  end

  // host chirp is a k followed by a j while waiting
  always_ff @(posedge clk) begin
    if (!rstn || (state_reg != USR_CHIRP_WAIT)) begin
      kseen_reg <= 1'b0;
    end else if (line_state == LS_K) begin
      kseen_reg <= 1'b1;
    end
  end

  // speed before suspend is remembered so resume returns to it
  always_ff @(posedge clk) begin
    if (!rstn) begin
      prev_hs_reg <= 1'b0;
    end else begin
      prev_hs_reg <= prev_hs_next;
    end
  end

  // ------------------------------------------------------------
  // outputs, registered from the next state
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      host_reset_active <= 1'b0;
      chirp_k_out <= 1'b0;
      hs_mode <= 1'b0;
    end else begin
      host_reset_active <= (state_next == USR_CHIRP_K) || (state_next == USR_CHIRP_WAIT);
      chirp_k_out <= (state_next == USR_CHIRP_K);
      hs_mode <= (state_next == USR_HS_OP) ||
                 (((state_next == USR_SUSPEND) || (state_next == USR_RESUME)) && prev_hs_next); // no stale first cycle
    end
  end

  // full speed selects both high; chirping runs hs transceiver with fs termination
  always_ff @(posedge clk) begin
    if (!rstn) begin
      transceiver_speed_sel <= 1'b1;
      termination_sel <= 1'b1;
    end else begin
      transceiver_speed_sel <= !((state_next == USR_HS_OP) || (state_next == USR_CHIRP_K) ||
                               (state_next == USR_CHIRP_WAIT));
      termination_sel <= (state_next != USR_HS_OP);
    end
  end

  // suspend output high from reset; bus idle pulls it low and only host traffic raises it again.
  // limitation: it rises on the next edge, so the system must keep the clock alive
  // long enough to see the resume k, or hold the phy clock running in suspend
  always_ff @(posedge clk) begin
    if (!rstn) begin
      suspend_n_out <= 1'b1;
    end else begin
      suspend_n_out <= (state_next != USR_SUSPEND);
    end
  end

  // ------------------------------------------------------------
  // register file: wiped at end of host reset, kept through suspend
  // ------------------------------------------------------------
  // the wipe wins over a same-cycle write so writes during reset are always lost
  always_ff @(posedge clk) begin
    if (!rstn || reset_end) begin
      cfg_reg <= CFG_RST;
    end else if (reg_we && (reg_sel == REG_SEL_CFG)) begin
      cfg_reg <= reg_wdata; // (writes need the phy clock running)
    end
  end

  // reset recognition aborts any dma transfer at once, not only at reset end
  always_ff @(posedge clk) begin
    if (!rstn || reset_end || (state_next == USR_CHIRP_K)) begin
      dma_port_state_reg <= DMA_STATE_RST;
    end else if (reg_we && (reg_sel == REG_SEL_DMA)) begin
      dma_port_state_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || reset_end || (state_next == USR_CHIRP_K)) begin
      bus_direct_mode <= 1'b0;
    end else if (reg_we && (reg_sel == REG_SEL_DMA)) begin
      bus_direct_mode <= reg_wdata[DMA_MODE_BIT];
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_rst_detect;
    $rose(host_reset_active) |-> chirp_k_out && ($past(se0_cnt) >= CNT_W'(RST_DET_CYC));
  endproperty
  a_rst_detect: assert property (p_rst_detect) else $error("reset flag rose without long se0");

  property p_chirp_end;
    $fell(chirp_k_out) && host_reset_active |-> $past(phase_cnt) >= CNT_W'(CHIRP_K_CYC);
  endproperty
  a_chirp_end: assert property (p_chirp_end) else $error("chirp-k ended at wrong time");

  property p_fs_fallback;
    $fell(host_reset_active) && transceiver_speed_sel |-> $past(phase_cnt) >= CNT_W'(CHIRP_WAIT_CYC);
  endproperty
  a_fs_fallback: assert property (p_fs_fallback) else $error("full speed chosen too early");

  property p_reg_init;
    $fell(host_reset_active) |-> (cfg_reg == CFG_RST) && (dma_port_state_reg == DMA_STATE_RST);
  endproperty
  a_reg_init: assert property (p_reg_init) else $error("registers not initialised at reset end");

  property p_dma_abort;
    $rose(host_reset_active) |-> (dma_port_state_reg == DMA_STATE_RST) && !bus_direct_mode;
  endproperty
  a_dma_abort: assert property (p_dma_abort) else $error("dma state survived host reset");

  property p_hs_idle;
    (state_reg == USR_HS_OP) && hit(idle_cnt, SUSP_DET_CYC) |=> transceiver_speed_sel && termination_sel;
  endproperty
  a_hs_idle: assert property (p_hs_idle) else $error("no fs fallback after hs idle");

  property p_check_j;
    (state_reg == USR_FS_CHECK) && hit(phase_cnt, FS_CHECK_CYC) && (line_state == LS_J) |=> !suspend_n_out;
  endproperty
  a_check_j: assert property (p_check_j) else $error("j after fallback did not suspend");

  property p_check_se0;
    (state_reg == USR_FS_CHECK) && hit(phase_cnt, FS_CHECK_CYC) && (line_state == LS_SE0)
      |=> suspend_n_out && (state_reg == USR_FS_OP);
  endproperty
  a_check_se0: assert property (p_check_se0) else $error("se0 after fallback entered suspend");

  property p_fs_susp;
    $fell(suspend_n_out) |-> $past(idle_cnt) >= CNT_W'(SUSP_DET_CYC) || $past(state_reg) == USR_FS_CHECK;
  endproperty
  a_fs_susp: assert property (p_fs_susp) else $error("suspend without 3 ms idle");

  property p_resume;
    (state_reg == USR_SUSPEND) && (line_state == LS_K) |=> suspend_n_out ##1 $stable(cfg_reg);
  endproperty
  a_resume: assert property (p_resume) else $error("host resume did not raise suspend output");

  property p_resume_speed;
    (state_reg == USR_RESUME) && (line_state == LS_SE0) |=> (hs_mode == prev_hs_reg);
  endproperty
  a_resume_speed: assert property (p_resume_speed) else $error("resume changed speed");

  c_reset_hs: cover property ($fell(host_reset_active) && !transceiver_speed_sel);
  c_reset_fs: cover property ($fell(host_reset_active) && transceiver_speed_sel);
  c_suspend: cover property ($fell(suspend_n_out));
  c_resume: cover property ($rose(suspend_n_out));

endmodule
`default_nettype wire

//--- dv/usr_host_model.sv
// usr_host_model: usb host seen through a utmi phy, as line_state and rx_active levels.
// assumes the bench calls its tasks from one process; every change lands 1 ns after a clk edge.
`timescale 1ns/1ns
`default_nettype none
module usr_host_model (
  // clock
  input wire logic clk,
  // utmi receive side towards the device
  output logic [1:0] line_state,
  output logic rx_active
);
  import usr_pkg::*;

  // ------------------------------------------------------------
  // line driver
  // ------------------------------------------------------------
  // a usb pair always shows a level, so the line is never left floating
  initial begin
    line_state = LS_J;
    rx_active = 1'b0;
  end

  // the bench keeps reset se0 up for many times the detect window before idle
  task automatic set_line(input logic [1:0] ls);
    @(posedge clk);
    #1;
    line_state = ls;
    rx_active = 1'b0;
  endtask

  // a packet toggles j and k with rx_active high; idle afterwards is se0 (hs) or j (fs)
  task automatic packet(input int len, input logic [1:0] idle);
    for (int i = 0; i < len; i++) begin
      @(posedge clk);
      #1;
      rx_active = 1'b1;
      line_state = i[0] ? LS_K : LS_J;
    end
    set_line(idle);
  endtask
endmodule
`default_nettype wire

//--- dv/tb.sv
// tb: self-checking bench for usr_link_state with shortened interval parameters.
// assumes usr_host_model as the line partner; all timing runs on one 100 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import usr_pkg::*;

  // ------------------------------------------------------------
  // shortened intervals and wiring
  // ------------------------------------------------------------
  localparam int RD = 8;
  localparam int CK = 20;
  localparam int CW = 30;
  localparam int SD = 40;
  localparam int FC = 10;
  logic clk, rstn, rx_active, reg_we, reg_sel;
  logic [1:0] line_state;
  logic [7:0] reg_wdata, cfg, dma;
  logic spd, term, chirp, hra, susp_n, hs, bdm;
  int err_count = 0;
  int num_checks = 0;
  int n;

  usr_link_state #(.RST_DET_CYC(RD), .CHIRP_K_CYC(CK), .CHIRP_WAIT_CYC(CW), .SUSP_DET_CYC(SD),
    .FS_CHECK_CYC(FC)) dut (.clk(clk), .rstn(rstn), .line_state(line_state), .rx_active(rx_active),
    .reg_we(reg_we), .reg_sel(reg_sel), .reg_wdata(reg_wdata), .transceiver_speed_sel(spd),
    .termination_sel(term), .chirp_k_out(chirp), .host_reset_active(hra), .suspend_n_out(susp_n),
    .hs_mode(hs), .cfg_reg(cfg), .dma_port_state_reg(dma), .bus_direct_mode(bdm));
  usr_host_model host (.clk(clk), .line_state(line_state), .rx_active(rx_active));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ------------------------------------------------------------
  // access and compare tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // interval counts carry a small window for the sampling edge of the line change
  task automatic chk_rng(input int got, input int lo, input int hi);
    num_checks++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, lo);
    end
  endtask

  task automatic wr(input logic sel, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_we = 1'b1;
    reg_sel = sel;
    reg_wdata = d;
    @(posedge clk);
    #1;
    reg_we = 1'b0;
  endtask

  function automatic logic sig_of(input int s);
    case (s)
      0: return hra;
      1: return chirp;
      2: return susp_n;
      default: return spd;
    endcase
  endfunction

  // bounded wait on an output; a timeout counts as a mismatch
  task automatic wait_until(input int s, input logic v, input int max, output int cnt);
    cnt = 0;
    while (sig_of(s) !== v && cnt < max) begin
      @(posedge clk);
      #1;
      cnt++;
    end
    if (cnt >= max) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, ~v, v);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    reg_we = 1'b0;
    reg_sel = 1'b0;
    reg_wdata = 8'h00;
    repeat (2) @(posedge clk);
    #1;
    rstn = 1'b1;
    chk({1'b0, susp_n, spd, term, hra, chirp, hs, bdm}, 8'h70);
    wr(REG_SEL_CFG, 8'h5a);
    wr(REG_SEL_DMA, 8'h01);
    chk({7'h00, bdm}, 8'h01);
    // reset with no host chirp falls back to full speed
    host.set_line(LS_SE0);
    wait_until(0, 1'b1, RD + 5, n);
    chk_rng(n, RD - 1, RD + 2);
    chk({7'h00, chirp}, 8'h01);
    chk({bdm, dma[6:0]}, 8'h00);
    wait_until(1, 1'b0, CK + 5, n);
    chk_rng(n, CK - 1, CK + 2);
    wr(REG_SEL_CFG, 8'h33);
    wait_until(0, 1'b0, CW + 5, n);
    chk_rng(n, CW - 3, CW + 2);
    chk({6'h00, spd, term}, 8'h03);
    chk(cfg, 8'h00);
    host.set_line(LS_J);
    // program only once the host reset period is over; the dma side is set up again too
    wr(REG_SEL_CFG, 8'hc3);
    wr(REG_SEL_DMA, 8'h01);
    chk({7'h00, bdm}, 8'h01);
    // full-speed idle j leads to suspend, then host resume
    host.packet(4, LS_J);
    wait_until(2, 1'b0, SD + 5, n);
    chk_rng(n, SD - 1, SD + 2);
    // wake-up comes only from the host; the system never asks for it early
    host.set_line(LS_K);
    // the system watches the output itself before letting the phy clock run again
    wait_until(2, 1'b1, 3, n);
    host.set_line(LS_SE0);
    host.set_line(LS_J);
    chk({6'h00, hs, spd}, 8'h01);
    chk(cfg, 8'hc3);
    chk(dma, 8'h01);
    // reset with host chirp k then j enters high speed
    host.set_line(LS_SE0);
    wait_until(0, 1'b1, RD + 5, n);
    chk({bdm, dma[6:0]}, 8'h00);
    wait_until(1, 1'b0, CK + 5, n);
    host.set_line(LS_K);
    host.set_line(LS_J);
    host.set_line(LS_SE0);
    wait_until(0, 1'b0, 4, n);
    chk({5'h00, hs, spd, term}, 8'h04);
    wr(REG_SEL_CFG, 8'h96);
    // high-speed idle: fallback, j check, suspend, resume to high speed
    host.packet(4, LS_SE0);
    wait_until(3, 1'b1, SD + 5, n);
    chk_rng(n, SD - 1, SD + 2);
    chk({7'h00, term}, 8'h01);
    host.set_line(LS_J);
    wait_until(2, 1'b0, FC + 5, n);
    chk_rng(n, FC - 3, FC + 2);
    chk({7'h00, hs}, 8'h01);
    host.set_line(LS_K);
    wait_until(2, 1'b1, 3, n);
    host.set_line(LS_SE0);
    repeat (2) @(posedge clk);
    #1;
    chk({5'h00, hs, spd, term}, 8'h04);
    chk(cfg, 8'h96);
    // se0 staying after fallback runs reset detection instead of suspend
    wait_until(3, 1'b1, SD + 5, n);
    wait_until(0, 1'b1, FC + RD + 8, n);
    chk_rng(n, FC + RD - 2, FC + RD + 3);
    chk({7'h00, susp_n}, 8'h01);
    finish_test();
  end

  // watchdog well above the few hundred cycles the sequence needs
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    finish_test();
  end
endmodule
`default_nettype wire
